// [hw/adc_cfg_pkg.sv]
// Purpose: shared constants and types of the two-wire slave front end
// Assumes: 100 MHz core clock
// Notes: addresses are 7-bit, without the read/write bit
package adc_cfg_pkg;

    // ==========================================================
    // timing
    localparam int CLK_PERIOD_NS = 10;
    // shortest pulse the input filter lets through, per speed mode
    localparam int SPIKE_FS_NS = 50;
    localparam int SPIKE_HS_NS = 10;
    localparam logic [3:0] SPIKE_FS_CYC = 4'((SPIKE_FS_NS / CLK_PERIOD_NS) > 0 ? SPIKE_FS_NS / CLK_PERIOD_NS : 1);
    localparam logic [3:0] SPIKE_HS_CYC = 4'((SPIKE_HS_NS / CLK_PERIOD_NS) > 0 ? SPIKE_HS_NS / CLK_PERIOD_NS : 1);

    // ==========================================================
    // addressing
    localparam logic [6:0] BASE_ADDR_STD = 7'h34;
    localparam logic [6:0] BASE_ADDR_ALT = 7'h36;
    localparam logic [4:0] MASTER_CODE_TOP = 5'h01;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;

    // ==========================================================
    // configuration byte layout
    localparam logic [7:0] CFG_RESET = 8'h01;
    localparam int CFG_TYPE_BIT = 7;
    localparam int CFG_SCAN_HI = 6;
    localparam int CFG_SCAN_LO = 5;
    localparam int CFG_CS3 = 4;
    localparam int CFG_CS2 = 3;
    localparam int CFG_CS1 = 2;
    localparam int CFG_CS0 = 1;
    localparam int CFG_SE = 0;
    localparam logic [3:0] REPEAT_COUNT = 4'h8;

    typedef enum logic [1:0] {
        SCAN_UP_TO = 2'h0,
        SCAN_REPEAT8 = 2'h1,
        SCAN_MONITOR = 2'h2,
        SCAN_SINGLE = 2'h3
    } scan_mode_e;

    // count of zero means continuous (monitor)
    typedef struct packed {
        scan_mode_e mode;
        logic [1:0] first_channel;
        logic [1:0] last_channel;
        logic [3:0] conv_count;
        logic monitor_readback;
        logic single_ended_select;
        logic unipolar_forced;
        logic diff_pair;
    } conv_plan_s;

    typedef enum logic [4:0] {
        ST_IDLE = 5'h01,
        ST_RX = 5'h02,
        ST_ACK = 5'h04,
        ST_TX = 5'h08,
        ST_MACK = 5'h10
    } bus_state_e;

endpackage : adc_cfg_pkg

// [hw/adc_i2c_slave_config_decode.sv]
// Purpose: two-wire bus slave with configuration-byte decode
// Assumes: SCL high and low phases each last at least 8 CLOCK periods
// Notes: open-drain data pin; SDA_OUT is always low, SDA_OE pulls
module adc_i2c_slave_config_decode #(
    parameter logic ALT_BASE = 1'b0
) (
    // core clock and reset
    input logic CLOCK,
    input logic RESET,
    // two-wire link
    input logic SCL_LINK,
    input logic SDA_IN,
    output logic SDA_OUT,
    output logic SDA_OE,
    // address strap
    input logic ADDR_SELECT_PIN,
    // read data source
    input logic [7:0] READ_BYTE,
    output logic READ_NEXT,
    // decoded configuration and setup
    output logic [7:0] CONFIG_BYTE,
    output adc_cfg_pkg::conv_plan_s CONV_PLAN,
    output logic [7:0] SETUP_BYTE,
    output logic SETUP_STROBE,
    output logic HIGH_SPEED_TIMING
);

    // ==========================================================
    // state types
    typedef struct packed {
        logic smp;
        logic tgl;
    } link_s;

    typedef struct packed {
        logic [1:0] pin_s1;
        logic [1:0] pin_s2;
        logic [1:0] line;
        logic [1:0] line_prev;
        logic [1:0][3:0] flt;
        logic sel_s1;
        logic sel_s2;
        logic tgl_s1;
        logic tgl_s2;
        logic tgl_s3;
        adc_cfg_pkg::bus_state_e st;
        logic [3:0] cnt;
        logic [7:0] sh;
        logic [7:0] tx;
        logic is_addr;
        logic reading;
        logic got_rise;
        logic acked;
        logic hs_arm;
        logic hs;
        logic drive_low;
        logic [7:0] config_byte;
        adc_cfg_pkg::conv_plan_s plan;
        logic [7:0] setup;
        logic setup_stb;
        logic read_take;
    } core_s;

    // ==========================================================
    // configuration decode
    function automatic adc_cfg_pkg::conv_plan_s decode_cfg(input logic [7:0] b);
        adc_cfg_pkg::conv_plan_s p;
        logic [1:0] chan;
        p = '0;
        chan = b[adc_cfg_pkg::CFG_CS1:adc_cfg_pkg::CFG_CS0];
        p.first_channel = b[adc_cfg_pkg::CFG_SCAN_LO] ? chan : 2'h0;
        p.last_channel = chan;
        p.mode = adc_cfg_pkg::scan_mode_e'(b[adc_cfg_pkg::CFG_SCAN_HI:adc_cfg_pkg::CFG_SCAN_LO]);
        unique case (p.mode)
            adc_cfg_pkg::SCAN_UP_TO:
                p.conv_count = {2'h0, chan} + 4'h1;
            adc_cfg_pkg::SCAN_REPEAT8:
                p.conv_count = adc_cfg_pkg::REPEAT_COUNT;
            adc_cfg_pkg::SCAN_MONITOR:
                p.conv_count = 4'h0;
            adc_cfg_pkg::SCAN_SINGLE:
                p.conv_count = 4'h1;
        endcase
        p.monitor_readback = b[adc_cfg_pkg::CFG_CS3] & b[adc_cfg_pkg::CFG_CS2];
        p.single_ended_select = b[adc_cfg_pkg::CFG_SE];
        p.diff_pair = chan[1];
        p.unipolar_forced = b[adc_cfg_pkg::CFG_SE];
        return p;
    endfunction : decode_cfg

    function automatic core_s core_reset();
        core_s r;
        r = '0;
        // idle bus reads high on both lines
        r.pin_s1 = 2'h3;
        r.pin_s2 = 2'h3;
        r.line = 2'h3;
        r.line_prev = 2'h3;
        r.st = adc_cfg_pkg::ST_IDLE;
        r.config_byte = adc_cfg_pkg::CFG_RESET;
        r.plan = decode_cfg(adc_cfg_pkg::CFG_RESET);
        return r;
    endfunction : core_reset

    // ==========================================================
    // link domain: sample data on each rising SCL edge
    link_s lk_reg;
    link_s lk_next;

    always_comb
    begin
        lk_next.smp = SDA_IN;
        lk_next.tgl = ~lk_reg.tgl;
    end

    always_ff @(posedge SCL_LINK or posedge RESET)
    begin
        if (RESET)
            lk_reg <= '0;
        else
            lk_reg <= lk_next;
    end

    // ==========================================================
    // core domain
    core_s s_reg;
    core_s s_next;
    logic [3:0] lim;
    logic [6:0] own_addr;
    logic start_ev;
    logic stop_ev;
    logic fall_ev;
    logic rise_ev;

    assign lim = s_reg.hs ? adc_cfg_pkg::SPIKE_HS_CYC : adc_cfg_pkg::SPIKE_FS_CYC;
    assign own_addr = (ALT_BASE ? adc_cfg_pkg::BASE_ADDR_ALT : adc_cfg_pkg::BASE_ADDR_STD) | {6'h00, s_reg.sel_s2};

    // line bit 1 is SCL, bit 0 is SDA
    assign start_ev = s_reg.line[1] & s_reg.line_prev[1] & s_reg.line_prev[0] & ~s_reg.line[0];
    assign stop_ev = s_reg.line[1] & s_reg.line_prev[1] & ~s_reg.line_prev[0] & s_reg.line[0];
    assign fall_ev = s_reg.line_prev[1] & ~s_reg.line[1];
    // sample is held stable until the next rising edge, so read it on the toggle
    assign rise_ev = s_reg.tgl_s2 ^ s_reg.tgl_s3;

    always_comb
    begin
        s_next = s_reg;
        s_next.setup_stb = 1'b0;
        s_next.read_take = 1'b0;
        s_next.pin_s1 = {SCL_LINK, SDA_IN};
        s_next.pin_s2 = s_reg.pin_s1;
        s_next.sel_s1 = ADDR_SELECT_PIN;
        s_next.sel_s2 = s_reg.sel_s1;
        s_next.tgl_s1 = lk_reg.tgl;
        s_next.tgl_s2 = s_reg.tgl_s1;
        s_next.tgl_s3 = s_reg.tgl_s2;
        s_next.line_prev = s_reg.line;
        for (int i = 0; i < 2; i++)
        begin
            if (s_reg.pin_s2[i] == s_reg.line[i])
                s_next.flt[i] = 4'h0;
            else if (s_reg.flt[i] + 4'h1 >= lim)
            begin
                s_next.line[i] = s_reg.pin_s2[i];
                s_next.flt[i] = 4'h0;
            end
            else
                s_next.flt[i] = s_reg.flt[i] + 4'h1;
        end

        if (stop_ev)
        begin
            s_next.st = adc_cfg_pkg::ST_IDLE;
            s_next.hs = 1'b0;
            s_next.hs_arm = 1'b0;
            s_next.drive_low = 1'b0;
        end
        else if (start_ev)
        begin
            // start or repeated start, speed kept
            s_next.st = adc_cfg_pkg::ST_RX;
            s_next.cnt = 4'h0;
            s_next.is_addr = 1'b1;
            s_next.hs_arm = 1'b0;
            s_next.drive_low = 1'b0;
        end
        else
        begin
            unique case (s_reg.st)
                adc_cfg_pkg::ST_IDLE:
                    s_next.drive_low = 1'b0;
                adc_cfg_pkg::ST_RX:
                begin
                    if (rise_ev && s_reg.cnt < adc_cfg_pkg::BITS_PER_BYTE)
                    begin
                        s_next.sh = {s_reg.sh[6:0], lk_reg.smp};
                        s_next.cnt = s_reg.cnt + 4'h1;
                    end
                    else if (fall_ev && s_reg.cnt == adc_cfg_pkg::BITS_PER_BYTE)
                    begin
                        s_next.cnt = 4'h0;
                        s_next.got_rise = 1'b0;
                        if (s_reg.is_addr)
                        begin
                            if (s_reg.sh[7:3] == adc_cfg_pkg::MASTER_CODE_TOP)
                            begin
                                s_next.st = adc_cfg_pkg::ST_ACK;
                                s_next.hs_arm = 1'b1;
                                s_next.drive_low = 1'b0;
                            end
                            else if (s_reg.sh[7:1] == own_addr)
                            begin
                                s_next.st = adc_cfg_pkg::ST_ACK;
                                s_next.reading = s_reg.sh[0];
                                s_next.drive_low = 1'b1;
                            end
                            else
                                s_next.st = adc_cfg_pkg::ST_IDLE;
                        end
                        else
                        begin
                            s_next.st = adc_cfg_pkg::ST_ACK;
                            s_next.reading = 1'b0;
                            s_next.drive_low = 1'b1;
                            if (s_reg.sh[adc_cfg_pkg::CFG_TYPE_BIT])
                            begin
                                s_next.setup = s_reg.sh;
                                s_next.setup_stb = 1'b1;
                            end
                            else
                            begin
                                s_next.config_byte = s_reg.sh;
                                s_next.plan = decode_cfg(s_reg.sh);
                            end
                        end
                    end
                end
                adc_cfg_pkg::ST_ACK:
                begin
                    if (rise_ev)
                        s_next.got_rise = 1'b1;
                    else if (fall_ev && s_reg.got_rise)
                    begin
                        s_next.got_rise = 1'b0;
                        s_next.drive_low = 1'b0;
                        s_next.cnt = 4'h0;
                        s_next.is_addr = 1'b0;
                        if (s_reg.hs_arm)
                        begin
                            s_next.hs = 1'b1;
                            s_next.hs_arm = 1'b0;
                            s_next.st = adc_cfg_pkg::ST_IDLE;
                        end
                        else if (s_reg.reading)
                        begin
                            // read: first bit goes out now
                            s_next.tx = READ_BYTE;
                            s_next.drive_low = ~READ_BYTE[7];
                            s_next.read_take = 1'b1;
                            s_next.st = adc_cfg_pkg::ST_TX;
                        end
                        else
                            s_next.st = adc_cfg_pkg::ST_RX;
                    end
                end
                adc_cfg_pkg::ST_TX:
                begin
                    if (rise_ev)
                        s_next.cnt = s_reg.cnt + 4'h1;
                    else if (fall_ev)
                    begin
                        if (s_reg.cnt == adc_cfg_pkg::BITS_PER_BYTE)
                        begin
                            s_next.drive_low = 1'b0;
                            s_next.got_rise = 1'b0;
                            s_next.st = adc_cfg_pkg::ST_MACK;
                        end
                        else
                        begin
                            s_next.tx = {s_reg.tx[6:0], 1'b0};
                            s_next.drive_low = ~s_reg.tx[6];
                        end
                    end
                end
                adc_cfg_pkg::ST_MACK:
                begin
                    if (rise_ev)
                    begin
                        // master ack sampled on ninth rise
                        s_next.got_rise = 1'b1;
                        s_next.acked = ~lk_reg.smp;
                    end
                    else if (fall_ev && s_reg.got_rise)
                    begin
                        s_next.got_rise = 1'b0;
                        s_next.cnt = 4'h0;
                        if (s_reg.acked)
                        begin
                            s_next.tx = READ_BYTE;
                            s_next.drive_low = ~READ_BYTE[7];
                            s_next.read_take = 1'b1;
                            s_next.st = adc_cfg_pkg::ST_TX;
                        end
                        else
                            s_next.st = adc_cfg_pkg::ST_IDLE;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge CLOCK or posedge RESET)
    begin
        if (RESET)
            s_reg <= core_reset();
        else
            s_reg <= s_next;
    end

    // ==========================================================
    // outputs
    assign SDA_OUT = 1'b0;
    assign SDA_OE = s_reg.drive_low;
    assign READ_NEXT = s_reg.read_take;
    assign CONFIG_BYTE = s_reg.config_byte;
    assign CONV_PLAN = s_reg.plan;
    assign SETUP_BYTE = s_reg.setup;
    assign SETUP_STROBE = s_reg.setup_stb;
    assign HIGH_SPEED_TIMING = s_reg.hs;

endmodule : adc_i2c_slave_config_decode

// [tb/adc_i2c_slave_config_decode_chk.sv]
// Purpose: port assertions of the two-wire slave
// Assumes: everything sampled on the core clock
// Notes: bound to every slave instance
module adc_i2c_slave_config_decode_chk (
    // core
    input logic CLOCK,
    input logic RESET,
    // link
    input logic SCL_LINK,
    input logic SDA_IN,
    input logic SDA_OUT,
    input logic SDA_OE,
    input logic ADDR_SELECT_PIN,
    // read source
    input logic [7:0] READ_BYTE,
    input logic READ_NEXT,
    // decoded outputs
    input logic [7:0] CONFIG_BYTE,
    input adc_cfg_pkg::conv_plan_s CONV_PLAN,
    input logic [7:0] SETUP_BYTE,
    input logic SETUP_STROBE,
    input logic HIGH_SPEED_TIMING
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge CLOCK);
    endclocking
    default disable iff (RESET);
    // ========
    // sequences
    sequence s_stop;
        SCL_LINK && $rose(SDA_IN);
    endsequence
    // plan is loaded in the same cycle as the byte
    sequence s_cfg_settled;
        $stable(CONFIG_BYTE) [*3];
    endsequence
    // ========
    // assertions
    a_drive_low: assert property (SDA_OUT == 1'b0)
        else $error("data value driven high");
    a_oe_scl_low: assert property ($changed(SDA_OE) |-> !SCL_LINK)
        else $error("data pull changed while bus clock high");
    a_cfg_type: assert property ($changed(CONFIG_BYTE) |-> !CONFIG_BYTE[7])
        else $error("configuration took a byte with top bit set");
    a_setup_type: assert property (SETUP_STROBE |-> ##1 (SETUP_BYTE[7] && !SETUP_STROBE))
        else $error("setup strobe wrong");
    a_plan_mode: assert property (s_cfg_settled |-> CONV_PLAN.mode == adc_cfg_pkg::scan_mode_e'(CONFIG_BYTE[6:5])
        && CONV_PLAN.last_channel == CONFIG_BYTE[2:1])
        else $error("plan mode or channel wrong");
    a_plan_bits: assert property (s_cfg_settled |-> CONV_PLAN.monitor_readback == &CONFIG_BYTE[4:3]
        && CONV_PLAN.single_ended_select == CONFIG_BYTE[0] && CONV_PLAN.unipolar_forced == CONFIG_BYTE[0])
        else $error("plan flags wrong");
    a_conv_count: assert property (s_cfg_settled |-> CONV_PLAN.conv_count ==
        (CONFIG_BYTE[6:5] == 2'h1 ? 4'h8 : CONFIG_BYTE[6:5] == 2'h2 ? 4'h0 :
        CONFIG_BYTE[6:5] == 2'h3 ? 4'h1 : {2'h0, CONFIG_BYTE[2:1]} + 4'h1))
        else $error("conversion count wrong");
    a_hs_rise: assert property ($rose(HIGH_SPEED_TIMING) |-> !SCL_LINK && !SDA_OE)
        else $error("high speed entered without release");
    a_hs_exit: assert property (HIGH_SPEED_TIMING ##0 s_stop |-> ##[1:12] !HIGH_SPEED_TIMING)
        else $error("stop did not leave high speed");
    a_hs_fall: assert property ($fell(HIGH_SPEED_TIMING) |-> SCL_LINK && SDA_IN)
        else $error("high speed left without stop");
    a_read_pulse: assert property (READ_NEXT |-> !SCL_LINK ##1 !READ_NEXT)
        else $error("read request pulse wrong");
endmodule : adc_i2c_slave_config_decode_chk

bind adc_i2c_slave_config_decode adc_i2c_slave_config_decode_chk u_adc_i2c_slave_config_decode_chk (
    .CLOCK, .RESET, .SCL_LINK, .SDA_IN, .SDA_OUT, .SDA_OE, .ADDR_SELECT_PIN, .READ_BYTE,
    .READ_NEXT, .CONFIG_BYTE, .CONV_PLAN, .SETUP_BYTE, .SETUP_STROBE, .HIGH_SPEED_TIMING
);

// [tb/i2c_host_model.sv]
// Purpose: behavioural bus master for the two-wire slave
// Assumes: pull-up on the data line, resolved outside
// Notes: ph is one clock phase in ns; raise it to run slowly
module i2c_host_model (
    // bus lines
    output logic scl,
    output logic sda_low,
    input wire logic sda
);
    timeunit 1ns;
    timeprecision 1ns;
    int ph = 200;
    initial
    begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    // ========
    // bit level
    // a one releases the line, a zero pulls it
    task automatic bit_x(input logic b, output logic r);
        #(ph / 4) sda_low = ~b;
        #(ph - ph / 4) scl = 1'b1;
        #(ph) r = sda;
        scl = 1'b0;
    endtask : bit_x
    // also serves as repeated start inside a frame
    task automatic start();
        #(ph / 4) sda_low = 1'b0;
        #(ph) scl = 1'b1;
        #(ph) sda_low = 1'b1;
        #(ph) scl = 1'b0;
    endtask : start
    task automatic stop();
        #(ph / 4) sda_low = 1'b1;
        #(ph) scl = 1'b1;
        #(ph) sda_low = 1'b0;
        #(ph);
    endtask : stop
    // ========
    // byte level
    task automatic wbyte(input logic [7:0] b, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--)
            bit_x(b[i], r);
        bit_x(1'b1, r);
        ack = ~r;
    endtask : wbyte
    task automatic rbyte(input logic nack, output logic [7:0] d);
        logic r;
        for (int i = 0; i < 8; i++)
        begin
            bit_x(1'b1, r);
            d = {d[6:0], r};
        end
        bit_x(nack, r);
    endtask : rbyte
endmodule : i2c_host_model

// [tb/adc_i2c_slave_config_decode_bench.sv]
// Purpose: self-checking bench of the two-wire slave
// Assumes: bus phases of 100 ns or more, so the core sees every edge
// Notes: two slaves share the bus, one per base address
module adc_i2c_slave_config_decode_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic clock, reset, addr_sel, scl, host_low, std_oe, alt_oe, high_speed, ack;
    logic read_next, setup_stb;
    logic [7:0] read_byte, std_cfg, alt_cfg, setup_byte, rd;
    adc_cfg_pkg::conv_plan_s plan;
    wire sda = ~(host_low | std_oe | alt_oe);
    int error_cnt = 0;
    int total_checks = 0;
    int read_cnt = 0;
    int setup_cnt = 0;
    adc_i2c_slave_config_decode u_adc_i2c_slave_config_decode (
        .CLOCK(clock), .RESET(reset), .SCL_LINK(scl), .SDA_IN(sda), .SDA_OUT(), .SDA_OE(std_oe),
        .ADDR_SELECT_PIN(addr_sel), .READ_BYTE(read_byte), .READ_NEXT(read_next), .CONFIG_BYTE(std_cfg),
        .CONV_PLAN(plan), .SETUP_BYTE(setup_byte), .SETUP_STROBE(setup_stb), .HIGH_SPEED_TIMING(high_speed));
    adc_i2c_slave_config_decode #(.ALT_BASE(1'b1)) u_adc_i2c_slave_config_decode_alt (
        .CLOCK(clock), .RESET(reset), .SCL_LINK(scl), .SDA_IN(sda), .SDA_OUT(), .SDA_OE(alt_oe),
        .ADDR_SELECT_PIN(addr_sel), .READ_BYTE(read_byte), .READ_NEXT(), .CONFIG_BYTE(alt_cfg),
        .CONV_PLAN(), .SETUP_BYTE(), .SETUP_STROBE(), .HIGH_SPEED_TIMING());
    i2c_host_model u_i2c_host_model (.scl(scl), .sda_low(host_low), .sda(sda));
    initial
    begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    // one-cycle pulses are counted so a missing or doubled pulse shows
    always @(posedge clock)
    begin
        if (read_next)
            read_cnt <= read_cnt + 1;
        if (setup_stb)
            setup_cnt <= setup_cnt + 1;
    end
    // ========
    // helpers
    task chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    function automatic adc_cfg_pkg::conv_plan_s plan_of(input logic [7:0] b);
        adc_cfg_pkg::conv_plan_s p;
        p.mode = adc_cfg_pkg::scan_mode_e'(b[6:5]);
        p.first_channel = b[5] ? b[2:1] : 2'h0;
        p.last_channel = b[2:1];
        case (b[6:5])
            2'h0: p.conv_count = {2'h0, b[2:1]} + 4'h1;
            2'h1: p.conv_count = 4'h8;
            2'h2: p.conv_count = 4'h0;
            default: p.conv_count = 4'h1;
        endcase
        p.monitor_readback = b[4] & b[3];
        p.single_ended_select = b[0];
        p.unipolar_forced = b[0];
        p.diff_pair = b[2];
        return p;
    endfunction : plan_of
    task wr(input logic [6:0] a, input logic [7:0] d, output logic ok);
        logic k;
        @(negedge clock);
        u_i2c_host_model.start();
        u_i2c_host_model.wbyte({a, 1'b0}, ok);
        // a refused address ends the frame, and the caller checks ok
        if (ok)
            u_i2c_host_model.wbyte(d, k);
        u_i2c_host_model.stop();
        repeat (20) @(negedge clock);
    endtask : wr
    // ========
    // scenarios
    task t_reset;
        chk(16'(std_cfg), 16'h0001);
        chk(16'(plan), 16'(plan_of(8'h01)));
        chk(16'(high_speed), 16'h0000);
    endtask : t_reset
    task t_address;
        logic [7:0] exp_std, exp_alt;
        exp_std = 8'h01;
        exp_alt = 8'h01;
        for (int s = 0; s < 2; s++)
            for (int i = 0; i < 4; i++)
            begin
                addr_sel = s[0];
                wr(7'h34 + 7'(i), 8'h40 + 8'(i), ack);
                if (i[0] == s[0] && i < 2)
                    exp_std = 8'h40 + 8'(i);
                if (i[0] == s[0] && i >= 2)
                    exp_alt = 8'h40 + 8'(i);
                chk(16'(ack), 16'(i[0] == s[0]));
                chk(16'(std_cfg), 16'(exp_std));
                chk(16'(alt_cfg), 16'(exp_alt));
            end
    endtask : t_address
    task t_config;
        logic [7:0] tbl [6] = '{8'h06, 8'h23, 8'h44, 8'h7F, 8'h19, 8'h5A};
        addr_sel = 1'b0;
        foreach (tbl[i])
        begin
            wr(7'h34, tbl[i], ack);
            chk(16'(std_cfg), 16'(tbl[i]));
            chk(16'(plan), 16'(plan_of(tbl[i])));
        end
        @(negedge clock);
        u_i2c_host_model.start();
        u_i2c_host_model.wbyte(8'h68, ack);
        u_i2c_host_model.wbyte(8'h25, ack);
        u_i2c_host_model.wbyte(8'h8A, ack);
        u_i2c_host_model.stop();
        repeat (20) @(negedge clock);
        chk(16'(ack), 16'h0001);
        chk(16'(setup_byte), 16'h008A);
        chk(16'(std_cfg), 16'h0025);
        chk(16'(setup_cnt), 16'h0001);
    endtask : t_config
    task t_hs;
        for (int k = 0; k < 2; k++)
        begin
            @(negedge clock);
            u_i2c_host_model.start();
            u_i2c_host_model.wbyte(8'h08 | 8'(k * 7), ack);
            repeat (12) @(negedge clock);
            chk(16'(ack), 16'h0000);
            chk(16'(high_speed), 16'h0001);
            // phase a multiple of the core period keeps edges off the sampling edge
            u_i2c_host_model.ph = 120;
            u_i2c_host_model.start();
            u_i2c_host_model.wbyte(8'h68, ack);
            u_i2c_host_model.wbyte(8'h0C + 8'(k), ack);
            chk(16'(high_speed), 16'h0001);
            chk(16'(std_cfg), 16'(8'h0C + 8'(k)));
            u_i2c_host_model.stop();
            repeat (20) @(negedge clock);
            chk(16'(high_speed), 16'h0000);
            u_i2c_host_model.ph = 200;
        end
    endtask : t_hs
    task t_read;
        read_byte = 8'hA5;
        @(negedge clock);
        u_i2c_host_model.start();
        u_i2c_host_model.wbyte(8'h69, ack);
        chk(16'(ack), 16'h0001);
        u_i2c_host_model.rbyte(1'b0, rd);
        chk(16'(rd), 16'h00A5);
        // next byte differs, so a stale load would show
        read_byte = 8'h3C;
        u_i2c_host_model.rbyte(1'b1, rd);
        chk(16'(rd), 16'h003C);
        u_i2c_host_model.stop();
        repeat (20) @(negedge clock);
        chk(16'(read_cnt), 16'h0002);
    endtask : t_read
    task print_verdict;
        if (error_cnt == 0 && total_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : print_verdict
    // ========
    // main sequence and watchdog
    initial
    begin
        reset = 1'b1;
        addr_sel = 1'b0;
        read_byte = 8'h00;
        repeat (20) @(negedge clock);
        reset = 1'b0;
        repeat (4) @(negedge clock);
        t_reset;
        t_address;
        t_config;
        t_hs;
        t_read;
        print_verdict;
    end
    // about 160 us expected, so 400 us means a hang
    initial
    begin
        #400000;
        error_cnt++;
        print_verdict;
    end
endmodule : adc_i2c_slave_config_decode_bench
